//--- usc_defines.svh
// Purpose: offsets, field positions, reset values and bit-time counts
//   for the second status and third control registers of the serial port.
// Assumes: 32-bit classic Wishbone, byte offsets, 8-bit registers in bits 7:0.
// Notes: the offsets, field positions and bit-time counts used by the design live here as macros.
// Behaviour
// - break flag sets on a detected break while break detection enabled; write 1 clears
// - edge flag sets on active receive edge, falling or rising per inversion
// - receive inversion flips the receive input for every receiver purpose
// - in standby, waking idle sets idle flag only when wake-idle-report is 1
// - transmit break is 10 or 13 bit times, one more in nine-bit mode
// - long transmit break never changes receive framing error detection
// - receive break threshold 10 bits, or 11 with break detection, +1 nine-bit
// - break detection enable blocks framing-error and buffer-full flags from setting
// - receiver-active sets on valid start bit, clears on idle line detection
// - received ninth bit reads in control three bit 7
// - data write sends nine bits using stored transmit ninth bit, which persists
// - single-wire mode: direction bit makes transmit pin input at 0, output at 1
// - transmit inversion flips the transmit output for every purpose
// - overrun flag and its enable raise an interrupt request
// - noise flag and its enable raise an interrupt request
// - framing-error flag and its enable raise an interrupt request
// - parity-error flag and its enable raise an interrupt request
// - character length selects eight or nine data bits, ten or eleven bit frame
// - idle means a full character time idle after activity
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH

// register byte offsets
`define USC_OFS_STATUS_TWO 8'h00
`define USC_OFS_CONTROL_THREE 8'h04

// serial_status_two fields
`define USC_S2_LBK_FLAG 7
`define USC_S2_EDGE_FLAG 6
`define USC_S2_RX_INVERT 4
`define USC_S2_WAKE_IDLE 3
`define USC_S2_LONG_BRK 2
`define USC_S2_LBK_EN 1
`define USC_S2_RX_ACTIVE 0

// serial_control_three fields
`define USC_C3_RX_NINTH 7
`define USC_C3_TX_NINTH 6
`define USC_C3_SW_DIR 5
`define USC_C3_TX_INVERT 4
`define USC_C3_OVR_IE 3
`define USC_C3_NOISE_IE 2
`define USC_C3_FRAME_IE 1
`define USC_C3_PARITY_IE 0

// reset values
`define USC_S2_RESET 8'h00
`define USC_C3_RESET 8'h00

// bit-time counts for eight data bits; nine-bit mode adds one
`define USC_FRAME_BITS 4'hA
`define USC_TX_BRK_SHORT 4'hA
`define USC_TX_BRK_LONG 4'hD
`define USC_RX_BRK_NORM 4'hA
`define USC_RX_BRK_LIN 4'hB

`endif

//--- usc_pkg.sv
// Purpose: types shared by the serial status/control logic.
// Assumes: usc_defines.svh supplies the offsets, field positions and bit-time counts.
// Notes: the line monitor and the status/control module each keep all of their state in one packed struct.
package usc_pkg;

  // state of the register and pin logic
  typedef struct packed {
    logic ack;
    logic [7:0] rdData;
    logic lbkFlag;
    logic edgeFlag;
    logic rxInvert;
    logic wakeIdleReport;
    logic longTxBreak;
    logic lbkDetectEn;
    logic rxActive;
    logic rxNinth;
    logic txNinth;
    logic singleWireDir;
    logic txInvert;
    logic [3:0] irqEn;
    logic rxLine;
    logic txPin;
    logic txPinOeN;
    logic [3:0] irqReq;
  } usc_main_state_t;

  // state of the line monitor
  typedef struct packed {
    logic [3:0] lowCnt;
    logic [3:0] highCnt;
    logic active;
    logic breakSeen;
    logic idleSeen;
  } usc_mon_state_t;

  // a base bit count, stretched by one in nine-bit mode
  function automatic logic [3:0] usc_bit_len(input logic [3:0] base, input logic nine);
    usc_bit_len = base + {3'h0, nine};
  endfunction : usc_bit_len

endpackage : usc_pkg

//--- usc_line_monitor.sv
// Purpose: watches the polarity-corrected receive line for breaks and idle.
// Assumes: bitTick pulses once per bit time at the bit sample point.
// Notes: the low count saturates so a held-low line reports one break only.
`timescale 1ns/1ps
`include "usc_defines.svh"
module usc_line_monitor
  import usc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic rxLine,
  input wire logic bitTick,
  input wire logic charNine,
  input wire logic lbkDetectEn,
  output logic breakSeen,
  output logic idleSeen
);

  usc_mon_state_t s;
  usc_mon_state_t next_s;
  logic [3:0] breakThr;
  logic [3:0] frameBits;

  // thresholds; transmit break length plays no part here
  assign breakThr = usc_bit_len(lbkDetectEn ? `USC_RX_BRK_LIN : `USC_RX_BRK_NORM,
                                charNine);
  assign frameBits = usc_bit_len(`USC_FRAME_BITS, charNine);

  // low-run and high-run counters, one step per bit time
  always_comb begin
    next_s = s;
    next_s.breakSeen = 1'b0;
    next_s.idleSeen = 1'b0;
    if (bitTick) begin
      if (!rxLine) begin
        next_s.highCnt = 4'h0;
        next_s.active = 1'b1;
        if (s.lowCnt != 4'hF) begin
          next_s.lowCnt = s.lowCnt + 4'h1;
        end
        if (s.lowCnt + 4'h1 == breakThr) begin
          next_s.breakSeen = 1'b1;
        end
      end else begin
        next_s.lowCnt = 4'h0;
        if (s.active) begin
          next_s.highCnt = s.highCnt + 4'h1;
          // a full character of idle only counts after some activity
          if (s.highCnt + 4'h1 == frameBits) begin
            next_s.idleSeen = 1'b1;
            next_s.active = 1'b0;
            next_s.highCnt = 4'h0;
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign breakSeen = s.breakSeen;
  assign idleSeen = s.idleSeen;

endmodule : usc_line_monitor

//--- usc_status_control.sv
// Purpose: second status and third control registers of the serial port,
//   with receive/transmit polarity, break and edge flags, receiver-active
//   status, ninth data bits, single-wire direction and error requests.
// Assumes: shifters, baud generator and first status register sit outside
//   and exchange strobes with this block on sys_clk.
// Notes: registers are reached over classic Wishbone; one-cycle ack.
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "usc_defines.svh"
module usc_status_control
  import usc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive pin and receiver side
  input wire logic rxPin,
  input wire logic bitTick,
  input wire logic charNine,
  input wire logic rxStandby,
  input wire logic startBitValid,
  input wire logic framingErrReq,
  input wire logic rxFullReq,
  input wire logic rxNinthIn,
  output logic rxLine,
  output logic framingErrSet,
  output logic rxFullSet,
  output logic idleFlagSet,
  // error flags held in the first status register
  input wire logic overrunFlag,
  input wire logic noiseFlag,
  input wire logic framingErrFlag,
  input wire logic parityErrFlag,
  output logic overrunIrq,
  output logic noiseIrq,
  output logic framingIrq,
  output logic parityIrq,
  output logic errIrq,
  // transmitter side and transmit pin
  input wire logic txLineRaw,
  input wire logic loopSelect,
  input wire logic rxSourceSelect,
  output logic [3:0] txBreakBits,
  output logic txNinthBit,
  output logic txPin,
  output logic txPinOeN
);

  usc_main_state_t s;
  usc_main_state_t next_s;

  // bus decode
  logic busReq;
  logic wrStatus;
  logic wrControl;
  logic [7:0] wrByte;

  // line events
  logic breakSeen;
  logic idleSeen;
  logic activeEdge;
  logic singleWire;

  // register images as software reads them
  logic [7:0] statusImage;
  logic [7:0] controlImage;

  // a new request is taken while no ack is out, so each access gets one ack
  assign busReq = wb_cyc_i && wb_stb_i && !s.ack;
  assign wrByte = wb_dat_i[7:0];
  // only byte lane 0 carries register data; other lanes are ignored
  assign wrStatus = busReq && wb_we_i && wb_sel_i[0] &&
                    (wb_adr_i == `USC_OFS_STATUS_TWO);
  assign wrControl = busReq && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == `USC_OFS_CONTROL_THREE);

  // break and idle timing on the corrected line
  usc_line_monitor u_monitor (
    .sys_clk(sys_clk),
    .srst(srst),
    .rxLine(s.rxLine),
    .bitTick(bitTick),
    .charNine(charNine),
    .lbkDetectEn(s.lbkDetectEn),
    .breakSeen(breakSeen),
    .idleSeen(idleSeen)
  );

  // the corrected line idles high, so an active edge is always high to low;
  // watching the corrected line covers both polarities in one comparator
  assign activeEdge = s.rxLine && !(rxPin ^ s.rxInvert);

  assign singleWire = loopSelect && rxSourceSelect;

  // status two as read: bit 5 is reserved and reads zero
  always_comb begin
    statusImage = 8'h00;
    statusImage[`USC_S2_LBK_FLAG] = s.lbkFlag;
    statusImage[`USC_S2_EDGE_FLAG] = s.edgeFlag;
    statusImage[`USC_S2_RX_INVERT] = s.rxInvert;
    statusImage[`USC_S2_WAKE_IDLE] = s.wakeIdleReport;
    statusImage[`USC_S2_LONG_BRK] = s.longTxBreak;
    statusImage[`USC_S2_LBK_EN] = s.lbkDetectEn;
    statusImage[`USC_S2_RX_ACTIVE] = s.rxActive;
  end

  // control three as read
  always_comb begin
    controlImage = 8'h00;
    controlImage[`USC_C3_RX_NINTH] = s.rxNinth;
    controlImage[`USC_C3_TX_NINTH] = s.txNinth;
    controlImage[`USC_C3_SW_DIR] = s.singleWireDir;
    controlImage[`USC_C3_TX_INVERT] = s.txInvert;
    controlImage[`USC_C3_OVR_IE] = s.irqEn[3];
    controlImage[`USC_C3_NOISE_IE] = s.irqEn[2];
    controlImage[`USC_C3_FRAME_IE] = s.irqEn[1];
    controlImage[`USC_C3_PARITY_IE] = s.irqEn[0];
  end

  // next-state logic for the whole block
  always_comb begin
    next_s = s;

    // bus answer: ack one cycle after the request, dropped the cycle after
    next_s.ack = busReq;
    if (busReq && !wb_we_i) begin
      // unmapped addresses read zero and are still acknowledged
      unique case (wb_adr_i)
        `USC_OFS_STATUS_TWO: next_s.rdData = statusImage;
        `USC_OFS_CONTROL_THREE: next_s.rdData = controlImage;
        default: next_s.rdData = 8'h00;
      endcase
    end

    // control bits of status two; flags and receiver-active are not written
    if (wrStatus) begin
      next_s.rxInvert = wrByte[`USC_S2_RX_INVERT];
      next_s.wakeIdleReport = wrByte[`USC_S2_WAKE_IDLE];
      next_s.longTxBreak = wrByte[`USC_S2_LONG_BRK];
      next_s.lbkDetectEn = wrByte[`USC_S2_LBK_EN];
    end

    // break flag: write 1 clears, 0 leaves it, a new break wins the cycle
    if (wrStatus && wrByte[`USC_S2_LBK_FLAG]) begin
      next_s.lbkFlag = 1'b0;
    end
    if (breakSeen && s.lbkDetectEn) begin
      next_s.lbkFlag = 1'b1;
    end

    // edge flag: same clearing scheme, held until software clears it
    if (wrStatus && wrByte[`USC_S2_EDGE_FLAG]) begin
      next_s.edgeFlag = 1'b0;
    end
    if (activeEdge) begin
      next_s.edgeFlag = 1'b1;
    end

    // receiver-active: a start bit in the same cycle as idle keeps it set
    if (idleSeen) begin
      next_s.rxActive = 1'b0;
    end
    if (startBitValid) begin
      next_s.rxActive = 1'b1;
    end

    // received ninth bit follows each character actually loaded
    if (rxFullReq && !s.lbkDetectEn) begin
      next_s.rxNinth = rxNinthIn;
    end

    // control three; bit 7 is read-only and writes to it are dropped
    if (wrControl) begin
      next_s.txNinth = wrByte[`USC_C3_TX_NINTH];
      next_s.singleWireDir = wrByte[`USC_C3_SW_DIR];
      next_s.txInvert = wrByte[`USC_C3_TX_INVERT];
      next_s.irqEn[3] = wrByte[`USC_C3_OVR_IE];
      next_s.irqEn[2] = wrByte[`USC_C3_NOISE_IE];
      next_s.irqEn[1] = wrByte[`USC_C3_FRAME_IE];
      next_s.irqEn[0] = wrByte[`USC_C3_PARITY_IE];
    end

    // receive input corrected once, so every receiver use sees one polarity
    next_s.rxLine = rxPin ^ s.rxInvert;

    // transmit output inverted after the shifter, covering break and idle too
    next_s.txPin = txLineRaw ^ s.txInvert;

    // pin driven except in single-wire mode with the direction bit low
    next_s.txPinOeN = singleWire && !s.singleWireDir;

    // error requests are levels: flag and enable both high
    next_s.irqReq[3] = overrunFlag && s.irqEn[3];
    next_s.irqReq[2] = noiseFlag && s.irqEn[2];
    next_s.irqReq[1] = framingErrFlag && s.irqEn[1];
    next_s.irqReq[0] = parityErrFlag && s.irqEn[0];
  end

  // state register; reset clears everything except rxLine and txPin, which reset high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.rxLine <= 1'b1;
      s.txPin <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // bus outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdData};

  // receiver strobes; with break detection on, framing and full are held off
  assign framingErrSet = framingErrReq && !s.lbkDetectEn;
  assign rxFullSet = rxFullReq && !s.lbkDetectEn;
  // idle in standby is reported only when asked for
  assign idleFlagSet = idleSeen && (!rxStandby || s.wakeIdleReport);

  // pins and line toward the shifters
  assign rxLine = s.rxLine;
  assign txPin = s.txPin;
  assign txPinOeN = s.txPinOeN;

  // break length for the transmitter; receiver framing ignores it
  assign txBreakBits = usc_bit_len(s.longTxBreak ? `USC_TX_BRK_LONG : `USC_TX_BRK_SHORT,
                                   charNine);
  // the shifter latches this with the data byte on each data write
  assign txNinthBit = s.txNinth;

  // interrupt requests
  assign overrunIrq = s.irqReq[3];
  assign noiseIrq = s.irqReq[2];
  assign framingIrq = s.irqReq[1];
  assign parityIrq = s.irqReq[0];
  assign errIrq = |s.irqReq;

endmodule : usc_status_control

//--- usc_remote_node.sv
// Purpose: remote serial node driving the receive pin of the port.
// Assumes: one bit time is BIT clocks; the line rests at mark.
// Notes: lineInv models an inverted line driver; bits leave lsb first.
`timescale 1ns/1ps
module usc_remote_node #(
  parameter int BIT = 4
) (
  input wire logic sys_clk,
  input wire logic lineInv,
  output logic rxPin
);
  logic mark = 1'b1;
  // a silent node leaves the wire at mark, never at the last data bit
  assign rxPin = mark ^ lineInv;
  // send n bits, each changed just after an edge and held a full bit time
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      mark <= bits[i];
      repeat (BIT) @(posedge sys_clk);
    end
    mark <= 1'b1;
  endtask : send
endmodule : usc_remote_node

//--- usc_status_control_checker.sv
// Purpose: concurrent checks on the serial status/control block.
// Assumes: one clock; writable fields other than the wake-idle report bit are mirrored from bus writes.
// Notes: the mirror updates on the same edge at which a write is taken.
`timescale 1ns/1ps
`include "usc_defines.svh"
module usc_status_control_checker
  import usc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic rxPin,
  input wire logic rxLine,
  input wire logic charNine,
  input wire logic framingErrReq,
  input wire logic rxFullReq,
  input wire logic framingErrSet,
  input wire logic rxFullSet,
  input wire logic overrunFlag,
  input wire logic noiseFlag,
  input wire logic framingErrFlag,
  input wire logic parityErrFlag,
  input wire logic overrunIrq,
  input wire logic noiseIrq,
  input wire logic framingIrq,
  input wire logic parityIrq,
  input wire logic errIrq,
  input wire logic txLineRaw,
  input wire logic loopSelect,
  input wire logic rxSourceSelect,
  input wire logic [3:0] txBreakBits,
  input wire logic txNinthBit,
  input wire logic txPin,
  input wire logic txPinOeN
);
  logic take;
  logic rxInvSh, lbkSh, longSh, t8Sh, dirSh, txInvSh;
  logic [3:0] ieSh;
  logic [3:0] gated;
  // a write lands only when taken with byte lane 0 enabled
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // error flags masked by the mirrored enables, overrun in bit 3
  assign gated = {overrunFlag, noiseFlag, framingErrFlag, parityErrFlag} & ieSh;
  // mirror of the writable control fields except the wake-idle report bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {rxInvSh, lbkSh, longSh, t8Sh, dirSh, txInvSh, ieSh} <= 10'h000;
    end else if (take && wb_adr_i == `USC_OFS_STATUS_TWO) begin
      {rxInvSh, longSh, lbkSh} <= {wb_dat_i[4], wb_dat_i[2:1]};
    end else if (take && wb_adr_i == `USC_OFS_CONTROL_THREE) begin
      {t8Sh, dirSh, txInvSh, ieSh} <= wb_dat_i[6:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // registered outputs still hold reset values on the first edge after it
  sequence s_run;
    !$past(srst);
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  chk_rx_polarity: assert property (s_run |->
    rxLine == ($past(rxPin) ^ $past(rxInvSh))) else $error("receive line polarity wrong");
  chk_tx_polarity: assert property (s_run |->
    txPin == ($past(txLineRaw) ^ $past(txInvSh))) else $error("transmit pin polarity wrong");
  chk_pin_dir: assert property (s_run |-> txPinOeN ==
    ($past(loopSelect) && $past(rxSourceSelect) && !$past(dirSh)))
    else $error("pin direction wrong");
  chk_irq_gate: assert property (s_run |->
    {overrunIrq, noiseIrq, framingIrq, parityIrq} == $past(gated))
    else $error("error request gating wrong");
  chk_err_any: assert property (s_run |->
    errIrq == (|$past(gated))) else $error("summary request wrong");
  chk_break_len: assert property ($stable(charNine) |->
    txBreakBits == ((longSh ? 4'hD : 4'hA) + {3'h0, charNine})) else $error("break length wrong");
  chk_ninth_tx: assert property (txNinthBit == t8Sh)
    else $error("ninth transmit bit lost");
  chk_fe_block: assert property (framingErrSet == (framingErrReq && !lbkSh))
    else $error("framing set not blocked");
  chk_full_block: assert property (rxFullSet == (rxFullReq && !lbkSh))
    else $error("buffer full set not blocked");
endmodule : usc_status_control_checker
bind usc_status_control usc_status_control_checker chk (.*);

//--- testbench.sv
// Purpose: self-checking bench for the serial status/control registers.
// Assumes: one-cycle bus answer; bitTick every 4 clocks.
// Notes: break thresholds are tried one bit short and at the limit.
`timescale 1ns/1ps
`include "usc_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench
  import usc_pkg::*;
;
  logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, selMask, txBreakBits;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic rxPin, bitTick, charNine, rxStandby, startBitValid, framingErrReq, rxFullReq;
  logic rxNinthIn, rxLine, framingErrSet, rxFullSet, idleFlagSet, overrunFlag, noiseFlag;
  logic framingErrFlag, parityErrFlag, overrunIrq, noiseIrq, framingIrq, parityIrq, errIrq;
  logic txLineRaw, loopSelect, rxSourceSelect, txNinthBit, txPin, txPinOeN, lineInv;
  logic [1:0] tickCnt;
  logic [7:0] q, d, expByte;
  logic b, nine, lbk, atLim, wake, longBrk;
  int fails, tests_run, idleCnt, base, len;
  int seed = 29342;
  usc_status_control uut (.*);
  usc_remote_node #(.BIT(4)) far (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // baud tick plus random flag and pin traffic, launched just after the edge
  always @(posedge sys_clk) begin
    tickCnt <= srst ? 2'h0 : tickCnt + 2'h1;
    bitTick <= (tickCnt == 2'h2);
    {overrunFlag, noiseFlag, framingErrFlag, parityErrFlag} <= 4'($random(seed));
    {txLineRaw, loopSelect, rxSourceSelect, framingErrReq} <= 4'($random(seed));
    if (idleFlagSet === 1'b1) idleCnt <= idleCnt + 1;
  end
  function automatic logic [7:0] exp_s2(input logic bk, eg, wk, lg, lb, ra);
    return {bk, eg, 2'h0, wk, lg, lb, ra};
  endfunction : exp_s2
  function automatic logic [7:0] exp_c3(input logic [7:0] w, input logic r8);
    return {r8, w[6:0]};
  endfunction : exp_c3
  task automatic final_report();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, a};
    {wb_sel_i, wb_dat_i} <= {selMask, 24'h0, v};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 20) begin
      fails++;
      final_report();
    end
  endtask : wb
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e, input string n);
    wb(1'b0, a, 8'h00);
    `CHK(n, e, q)
  endtask : expect_reg
  task automatic pulse_full(input logic r8);
    @(posedge sys_clk);
    {rxFullReq, rxNinthIn} <= {1'b1, r8};
    @(posedge sys_clk);
    rxFullReq <= 1'b0;
  endtask : pulse_full
  // main sequence
  initial begin
    {srst, wb_cyc_i, wb_stb_i, wb_we_i, startBitValid, rxFullReq, rxNinthIn} = 7'h40;
    {wb_adr_i, wb_sel_i, wb_dat_i, selMask} = 48'h0;
    {charNine, rxStandby, lineInv} = 3'h0;
    selMask = 4'hF;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    expect_reg(`USC_OFS_STATUS_TWO, 8'h00, "s2 reset");
    expect_reg(`USC_OFS_CONTROL_THREE, 8'h00, "c3 reset");
    wb(1'b1, 8'h08, 8'hFF);
    expect_reg(8'h08, 8'h00, "unmapped");
    selMask = 4'hE;
    wb(1'b1, `USC_OFS_CONTROL_THREE, 8'hFF);
    selMask = 4'hF;
    expect_reg(`USC_OFS_CONTROL_THREE, 8'h00, "lane off");
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'hEE);
    expect_reg(`USC_OFS_STATUS_TWO, 8'h0E, "s2 access");
    $display("done: register access");
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'h00);
    for (int i = 0; i < 16; i++) begin
      {b, d} = 9'($random(seed));
      wb(1'b1, `USC_OFS_CONTROL_THREE, d);
      pulse_full(b);
      expect_reg(`USC_OFS_CONTROL_THREE, exp_c3(d, b), "c3 ninth");
    end
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'h02);
    pulse_full(~b);
    expect_reg(`USC_OFS_CONTROL_THREE, exp_c3(d, b), "no load");
    $display("done: ninth bits");
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'h10);
    lineInv <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'hD0);
    expect_reg(`USC_OFS_STATUS_TWO, 8'h10, "edge clear");
    far.send(16'h0000, 1);
    expect_reg(`USC_OFS_STATUS_TWO, 8'h50, "rising edge");
    wb(1'b1, `USC_OFS_STATUS_TWO, 8'h10);
    expect_reg(`USC_OFS_STATUS_TWO, 8'h50, "edge sticky");
    lineInv <= 1'b0;
    repeat (4) @(posedge sys_clk);
    $display("done: edge flag");
    for (int k = 0; k < 8; k++) begin
      {nine, lbk, atLim} = 3'(k);
      len = (lbk ? 11 : 10) + int'(nine) - 1 + int'(atLim);
      wake = nine ^ atLim;
      // long transmit break varies across cases; detection must not follow it
      longBrk = nine ^ lbk;
      charNine <= nine;
      // standby dropped in the last pair so idle is reported whatever wake says
      rxStandby <= ~(lbk & nine);
      wb(1'b1, `USC_OFS_STATUS_TWO, {2'h3, 2'h0, wake, longBrk, lbk, 1'b0});
      base = idleCnt;
      startBitValid <= 1'b1;
      @(posedge sys_clk);
      startBitValid <= 1'b0;
      expByte = exp_s2(1'b0, 1'b0, wake, longBrk, lbk, 1'b1);
      expect_reg(`USC_OFS_STATUS_TWO, expByte, "active");
      far.send(16'h0000, len);
      pulse_full(1'b0);
      repeat (60) @(posedge sys_clk);
      expByte = exp_s2(lbk & atLim, 1'b1, wake, longBrk, lbk, 1'b0);
      expect_reg(`USC_OFS_STATUS_TWO, expByte, "break");
      `CHK("idle flag", wake | (lbk & nine), (idleCnt != base))
    end
    $display("done: break and idle");
    wb(1'b1, `USC_OFS_CONTROL_THREE, 8'h7F);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    expect_reg(`USC_OFS_CONTROL_THREE, 8'h00, "re-reset");
    expect_reg(`USC_OFS_STATUS_TWO, 8'h00, "s2 re-reset");
    $display("done: second reset");
    final_report();
  end
endmodule : testbench
